// [src/flash_bus_pkg.sv]
package flash_bus_pkg;
  localparam int ADDR_W    = 19;
  localparam int DATA_W    = 16;
  localparam int CNT_W     = 5;
  localparam int CMD_W     = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_W    = 8 + ADDR_W + DATA_W;
  localparam logic [CNT_W-1:0] CNT_START = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST  = 5'h1F;
  localparam logic [CNT_W-1:0] CNT_STEP  = 5'h01;
  localparam int PROT_SEL_BIT = 6;
  localparam int PROT_A1_BIT  = 1;
  localparam int PROT_A0_BIT  = 0;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  localparam logic [7:0] CTRL_RESET = 8'hF3;
  typedef enum logic [0:0] {MODE_ARRAY_READ, MODE_COMMAND} read_mode_t;
endpackage : flash_bus_pkg

// [src/burst_flash_bus_operation_decoder.sv]
`timescale 1ns/100ps

// two-stage pin synchroniser
module pin_sync #(
  parameter int                W     = 1,
  parameter logic [W-1:0]      INIT  = '0
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] pin_s
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = reset ? INIT : pin;
    sync_d = reset ? INIT : meta_q;
  end

  always_ff @(posedge mclk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign pin_s = sync_q;
endmodule : pin_sync

// command latch queue
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    wr_d;
  logic [PW-1:0]    rd_q;
  logic [PW-1:0]    rd_d;
  logic [PW:0]      cnt_q;
  logic [PW:0]      cnt_d;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = (cnt_q != (PW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data  = mem_q[rd_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d      = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d     = cnt_q;
    if (push && !pop) begin
      cnt_d = (PW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (PW+1)'(cnt_q - 1'b1);
    end
    if (reset) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    wr_q  <= wr_d;
    rd_q  <= rd_d;
    cnt_q <= cnt_d;
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : cmd_fifo

// Function
// R1: chip select and output enable low, write enable high: drive addressed word.
// R2: write cycles land in command latches for the state machine, never in array.
// R3: after reset the block starts in array-read state.
// R4: array-read state is left only by a write, never by reads.
// R5: output enable high keeps data lines released.
// R6: chip select high ignores the bus and releases data lines.
// R7: load low, advance high at clock edge latches start address, starts burst.
// R8: advance with output enable high steps address, data stays released.
// R9: advance with output enable low steps address and drives next word.
// R10: chip select high ends the current burst and releases data lines; code ends the burst only while write enable is also high.
// R11: a load during an active burst restarts from the new address.
// R12: output enable and both strobes high suspend, holding word and position.
// R13: output enable low with strobes high resumes with the same held word.
// R14: output enable and advance low resume by stepping at next clock edge.
// R15: elevated reset level with write pulses protect or unprotect by A6.
// R16: reset pin low aborts, releases data and leaves burst mode.
// R17: burst clock and strobes ignored unless burst mode is enabled.
// R18: 5-bit counter cleared at load, last-word low at all ones, then wraps.
// R19: advance high holds burst position and output word.
// R20: undefined control combinations are no-operations with data released.
module burst_flash_bus_operation_decoder (
  input  wire logic                                mclk,
  input  wire logic                                reset,
  input  wire logic                                chip_select_n,
  input  wire logic                                output_enable_n,
  input  wire logic                                write_enable_n,
  input  wire logic                                hw_reset_n,
  input  wire logic                                elevated_identification_level,
  input  wire logic                                burst_clk,
  input  wire logic                                burst_address_load_n,
  input  wire logic                                burst_advance_n,
  input  wire logic [flash_bus_pkg::ADDR_W-1:0]    address_lines,
  input  wire logic [flash_bus_pkg::DATA_W-1:0]    data_lines_in,
  output logic      [flash_bus_pkg::DATA_W-1:0]    data_lines_out,
  output logic                                     data_lines_oe,
  output logic                                     burst_last_word_n,
  output logic      [flash_bus_pkg::ADDR_W-1:0]    array_addr,
  input  wire logic [flash_bus_pkg::DATA_W-1:0]    array_rdata,
  input  wire logic [flash_bus_pkg::DATA_W-1:0]    status_rdata,
  input  wire logic                                burst_mode_enable,
  input  wire logic                                command_done,
  output logic                                     cmd_valid,
  input  wire logic                                cmd_ready,
  output logic      [flash_bus_pkg::ADDR_W-1:0]    cmd_addr,
  output logic      [flash_bus_pkg::DATA_W-1:0]    cmd_data,
  output logic                                     sector_protect,
  output logic                                     sector_unprotect,
  output logic      [flash_bus_pkg::ADDR_W-1:0]    sector_addr,
  output logic                                     hw_reset_active
);
  localparam int AW = flash_bus_pkg::ADDR_W;
  localparam int DW = flash_bus_pkg::DATA_W;
  localparam int CW = flash_bus_pkg::CNT_W;

  logic [flash_bus_pkg::SYNC_W-1:0] pins_s;
  logic          ce_n_s, oe_n_s, we_n_s, rst_n_s, vid_s, bclk_s;
  logic          load_n_s, adv_n_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] din_s;

  pin_sync #(
    .W    (flash_bus_pkg::SYNC_W),
    .INIT ({flash_bus_pkg::CTRL_RESET, flash_bus_pkg::ADDR_RESET,
            flash_bus_pkg::DATA_RESET})
  ) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .pin   ({chip_select_n, output_enable_n, write_enable_n, hw_reset_n,
             elevated_identification_level, burst_clk,
             burst_address_load_n, burst_advance_n,
             address_lines, data_lines_in}),
    .pin_s (pins_s)
  );

  assign {ce_n_s, oe_n_s, we_n_s, rst_n_s, vid_s, bclk_s, load_n_s, adv_n_s,
          addr_s, din_s} = pins_s;

  // edge and mode state
  logic                      bclk_q, bclk_d, we_n_q, we_n_d;
  flash_bus_pkg::read_mode_t mode_q, mode_d;
  logic                      active_q, active_d;
  logic [AW-1:0]             base_q, base_d;
  logic [CW-1:0]             cnt_q, cnt_d;
  logic [AW-1:0]             wr_addr_q, wr_addr_d;
  logic [DW-1:0]             wr_data_q, wr_data_d;
  logic                      pend_q, pend_d;
  logic                      prot_q, prot_d, unprot_q, unprot_d;
  logic [AW-1:0]             saddr_q, saddr_d;
  logic [DW-1:0]             dout_q, dout_d;
  logic                      oe_q, oe_d, last_n_q, last_n_d;
  logic                      clk_rise, we_rise, in_reset, normal, burst_on;
  logic                      selected, wr_cycle, prot_cycle, fifo_ready;
  logic [CW-1:0]             word_idx;

  always_comb begin
    clk_rise   = bclk_s && !bclk_q;
    we_rise    = we_n_s && !we_n_q;
    in_reset   = !rst_n_s && !vid_s;
    normal     = rst_n_s && !vid_s;
    selected   = !ce_n_s;
    // R17 burst gate
    burst_on   = burst_mode_enable && normal;
    wr_cycle   = selected && oe_n_s && normal;
    prot_cycle = selected && oe_n_s && vid_s
                 && addr_s[flash_bus_pkg::PROT_A1_BIT]
                 && !addr_s[flash_bus_pkg::PROT_A0_BIT];
    word_idx   = CW'(base_q[CW-1:0] + cnt_q);

    bclk_d    = bclk_s;
    we_n_d    = we_n_s;
    mode_d    = mode_q;
    active_d  = active_q;
    base_d    = base_q;
    cnt_d     = cnt_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    pend_d    = pend_q && !fifo_ready;
    prot_d    = 1'b0;
    unprot_d  = 1'b0;
    saddr_d   = saddr_q;

    if (command_done) begin
      mode_d = flash_bus_pkg::MODE_ARRAY_READ;
    end
    // R2 latch command
    if (wr_cycle && !we_n_s && !pend_q) begin
      wr_addr_d = addr_s;
      wr_data_d = din_s;
    end
    if (wr_cycle && we_rise && !pend_q) begin
      pend_d = 1'b1;
      // R4 leave read state
      mode_d = flash_bus_pkg::MODE_COMMAND;
    end
    // R15 protect pulses
    if (prot_cycle && we_rise) begin
      prot_d   = !addr_s[flash_bus_pkg::PROT_SEL_BIT];
      unprot_d = addr_s[flash_bus_pkg::PROT_SEL_BIT];
      saddr_d  = addr_s;
    end

    // R10 terminate burst
    if (!selected && we_n_s) begin
      active_d = 1'b0;
    end else if (burst_on && selected && we_n_s && clk_rise) begin
      if (!load_n_s && adv_n_s) begin
        // R7 R11 R18 load
        base_d   = addr_s;
        cnt_d    = flash_bus_pkg::CNT_START;
        active_d = 1'b1;
      end else if (load_n_s && !adv_n_s && active_q) begin
        // R8 R9 R14 R18 step
        cnt_d = CW'(cnt_q + flash_bus_pkg::CNT_STEP);
      end
      // R12 R13 R19 hold otherwise
    end
    if (!burst_on) begin
      active_d = 1'b0;
    end

    // R1 R5 R6 R20 driver gate
    oe_d     = selected && !oe_n_s && we_n_s && normal;
    last_n_d = !(active_q && cnt_q == flash_bus_pkg::CNT_LAST);
    if (mode_q == flash_bus_pkg::MODE_COMMAND && !active_q) begin
      dout_d = status_rdata;
    end else begin
      dout_d = array_rdata;
    end

    // R3 R16 reset state
    if (reset || in_reset) begin
      mode_d   = flash_bus_pkg::MODE_ARRAY_READ;
      active_d = 1'b0;
      cnt_d    = flash_bus_pkg::CNT_START;
      oe_d     = 1'b0;
      last_n_d = 1'b1;
      prot_d   = 1'b0;
      unprot_d = 1'b0;
    end
    if (reset) begin
      bclk_d    = 1'b0;
      we_n_d    = 1'b1;
      base_d    = flash_bus_pkg::ADDR_RESET;
      wr_addr_d = flash_bus_pkg::ADDR_RESET;
      wr_data_d = flash_bus_pkg::DATA_RESET;
      pend_d    = 1'b0;
      saddr_d   = flash_bus_pkg::ADDR_RESET;
      dout_d    = flash_bus_pkg::DATA_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    bclk_q    <= bclk_d;
    we_n_q    <= we_n_d;
    mode_q    <= mode_d;
    active_q  <= active_d;
    base_q    <= base_d;
    cnt_q     <= cnt_d;
    wr_addr_q <= wr_addr_d;
    wr_data_q <= wr_data_d;
    pend_q    <= pend_d;
    prot_q    <= prot_d;
    unprot_q  <= unprot_d;
    saddr_q   <= saddr_d;
    dout_q    <= dout_d;
    oe_q      <= oe_d;
    last_n_q  <= last_n_d;
  end

  // R2 queue to state machine
  cmd_fifo #(
    .WIDTH (flash_bus_pkg::CMD_W),
    .DEPTH (flash_bus_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (pend_q),
    .in_ready  (fifo_ready),
    .in_data   ({wr_addr_q, wr_data_q}),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  ({cmd_addr, cmd_data})
  );

  // R9 burst address select
  assign array_addr        = active_q ? {base_q[AW-1:CW], word_idx} : addr_s;
  assign data_lines_out    = dout_q;
  assign data_lines_oe     = oe_q;
  assign burst_last_word_n = last_n_q;
  assign sector_protect    = prot_q;
  assign sector_unprotect  = unprot_q;
  assign sector_addr       = saddr_q;
  assign hw_reset_active   = in_reset;
endmodule : burst_flash_bus_operation_decoder

// [tb/flash_far_model.sv]
`timescale 1ns/100ps

// array, status word and command sink
module flash_far_model (
  input  wire logic [18:0] array_addr,
  input  wire logic        stall,
  output logic      [15:0] array_rdata,
  output logic      [15:0] status_rdata,
  output logic             cmd_ready
);
  assign array_rdata  = array_addr[15:0] ^ {array_addr[18:16], 13'h00A5};
  assign status_rdata = 16'hC3E1;
  assign cmd_ready    = !stall;
endmodule : flash_far_model

// [tb/bus_decoder_checker.sv]
`timescale 1ns/100ps

module bus_decoder_checker (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        chip_select_n,
  input wire logic        output_enable_n,
  input wire logic        write_enable_n,
  input wire logic        hw_reset_n,
  input wire logic        elevated_identification_level,
  input wire logic        data_lines_oe,
  input wire logic        burst_last_word_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [18:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic        sector_protect,
  input wire logic        sector_unprotect,
  input wire logic        hw_reset_active
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  wire logic pulse = sector_protect || sector_unprotect;
  wire logic hwr   = !hw_reset_n && !elevated_identification_level;
  wire logic rd    = !chip_select_n && !output_enable_n && write_enable_n;

  chk_reset_quiet: assert property (disable iff (1'b0)
    reset |=> !data_lines_oe && !cmd_valid && burst_last_word_n)
    else $error("outputs active after reset");
  chk_read_drive: assert property (
    (rd && hw_reset_n && !elevated_identification_level)[*5]
      |-> data_lines_oe)
    else $error("read not driven");
  chk_oe_gate: assert property (
    (!chip_select_n && output_enable_n)[*5] |-> !data_lines_oe)
    else $error("driven with oe high");
  chk_deselect_release: assert property (
    chip_select_n[*5] |-> !data_lines_oe)
    else $error("driven while deselected");
  chk_nop_release: assert property (
    (!output_enable_n && !write_enable_n)[*5] |-> !data_lines_oe)
    else $error("driven on undefined combination");
  chk_hw_abort: assert property (
    hwr[*5] |-> !data_lines_oe && burst_last_word_n)
    else $error("hardware reset not aborting");
  chk_hw_flag: assert property (
    hwr[*4] |-> hw_reset_active)
    else $error("reset flag missing");
  chk_cmd_hold: assert property (
    cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_addr, cmd_data}))
    else $error("command dropped while stalled");
  chk_prot_pulse: assert property (
    pulse |-> !(sector_protect && sector_unprotect) ##1 !pulse)
    else $error("protect pulse malformed");
  chk_prot_level: assert property (
    pulse |-> $past(elevated_identification_level, 4))
    else $error("protect without elevated level");

  cover property (sector_protect);
  cover property (sector_unprotect);
  cover property (!burst_last_word_n);
  cover property (cmd_valid && !cmd_ready);
endmodule : bus_decoder_checker

// [tb/burst_flash_bus_operation_decoder_bench.sv]
`timescale 1ns/100ps

module burst_flash_bus_operation_decoder_bench;
  logic        mclk = 0, reset = 1, chip_select_n = 1, output_enable_n = 1;
  logic        write_enable_n = 1, hw_reset_n = 1, burst_clk = 0, stall = 0;
  logic        elevated_identification_level = 0, command_done = 0;
  logic        burst_address_load_n = 1, burst_advance_n = 1;
  logic        burst_mode_enable = 0;
  logic [18:0] address_lines = 0, array_addr, cmd_addr, sector_addr, base;
  logic [15:0] data_lines_in = 0, data_lines_out, array_rdata, status_rdata;
  logic [15:0] cmd_data;
  logic        data_lines_oe, burst_last_word_n, cmd_valid, cmd_ready;
  logic        sector_protect, sector_unprotect, hw_reset_active;
  logic [34:0] got_q[$], exp_q[$];
  logic [31:0] s = 32'hA1F8;
  int          fail_count = 0, n_checks = 0, prot_n = 0, unprot_n = 0;

  burst_flash_bus_operation_decoder dut (
    .mclk                          (mclk),
    .reset                         (reset),
    .chip_select_n                 (chip_select_n),
    .output_enable_n               (output_enable_n),
    .write_enable_n                (write_enable_n),
    .hw_reset_n                    (hw_reset_n),
    .elevated_identification_level (elevated_identification_level),
    .burst_clk                     (burst_clk),
    .burst_address_load_n          (burst_address_load_n),
    .burst_advance_n               (burst_advance_n),
    .address_lines                 (address_lines),
    .data_lines_in                 (data_lines_in),
    .data_lines_out                (data_lines_out),
    .data_lines_oe                 (data_lines_oe),
    .burst_last_word_n             (burst_last_word_n),
    .array_addr                    (array_addr),
    .array_rdata                   (array_rdata),
    .status_rdata                  (status_rdata),
    .burst_mode_enable             (burst_mode_enable),
    .command_done                  (command_done),
    .cmd_valid                     (cmd_valid),
    .cmd_ready                     (cmd_ready),
    .cmd_addr                      (cmd_addr),
    .cmd_data                      (cmd_data),
    .sector_protect                (sector_protect),
    .sector_unprotect              (sector_unprotect),
    .sector_addr                   (sector_addr),
    .hw_reset_active               (hw_reset_active)
  );
  flash_far_model far (
    .array_addr   (array_addr),
    .stall        (stall),
    .array_rdata  (array_rdata),
    .status_rdata (status_rdata),
    .cmd_ready    (cmd_ready)
  );

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (cmd_valid && cmd_ready) got_q.push_back({cmd_addr, cmd_data});
    prot_n += sector_protect;
    unprot_n += sector_unprotect;
  end

  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd

  function automatic logic [15:0] word(input logic [18:0] a);
    return a[15:0] ^ {a[18:16], 13'h00A5};
  endfunction : word

  function automatic logic [18:0] bad(input logic [18:0] b, input int n);
    return {b[18:5], 5'(b[4:0] + n)};
  endfunction : bad

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic pins(input logic c, input logic o, input logic w);
    chip_select_n = c;
    output_enable_n = o;
    write_enable_n = w;
    cyc(6);
  endtask : pins

  task automatic bclk(input logic ld, input logic adv);
    burst_address_load_n = ld;
    burst_advance_n = adv;
    burst_clk = 1;
    cyc(4);
    burst_clk = 0;
    cyc(4);
  endtask : bclk

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  initial begin
    cyc(8);
    reset = 0;
    cyc(2);
    chk(data_lines_oe, 0);
    for (int i = 0; i < 4; i++) begin
      address_lines = 19'(rnd());
      pins(0, 0, 1);
      chk(data_lines_oe, 1);
      chk(data_lines_out, word(address_lines));
    end
    pins(0, 1, 1);
    chk(data_lines_oe, 0);
    pins(1, 0, 1);
    chk(data_lines_oe, 0);
    pins(0, 0, 0);
    chk(data_lines_oe, 0);
    stall = 1;
    for (int i = 0; i < 6; i++) begin
      address_lines = 19'(rnd());
      data_lines_in = 16'(rnd());
      pins(0, 1, 0);
      if (i < 5) exp_q.push_back({address_lines, data_lines_in});
      pins(0, 1, 1);
    end
    stall = 0;
    pins(0, 0, 1);
    chk(got_q.size(), 5);
    foreach (exp_q[k]) chk(got_q[k], exp_q[k]);
    chk(data_lines_out, status_rdata);
    command_done = 1;
    cyc(1);
    command_done = 0;
    base = 19'(rnd());
    bclk(0, 1);
    address_lines = base;
    cyc(6);
    chk(data_lines_out, word(base));
    burst_mode_enable = 1;
    bclk(0, 1);
    for (int i = 0; i < 34; i++) begin
      if (i > 0) bclk(1, 0);
      chk(data_lines_out, word(bad(base, i)));
      chk(array_addr, bad(base, i));
      chk(burst_last_word_n, i % 32 != 31);
    end
    bclk(1, 1);
    chk(data_lines_out, word(bad(base, 33)));
    pins(0, 1, 1);
    bclk(1, 1);
    chk(data_lines_oe, 0);
    pins(0, 0, 1);
    chk(data_lines_out, word(bad(base, 33)));
    bclk(1, 0);
    chk(data_lines_out, word(bad(base, 34)));
    output_enable_n = 1;
    bclk(1, 0);
    chk(data_lines_oe, 0);
    address_lines = 19'(rnd());
    pins(0, 0, 1);
    chk(data_lines_out, word(bad(base, 35)));
    bclk(0, 1);
    chk(data_lines_out, word(address_lines));
    pins(1, 0, 1);
    chk(data_lines_oe, 0);
    base = address_lines;
    address_lines = 19'(rnd());
    pins(0, 0, 1);
    chk(data_lines_out, word(address_lines));
    address_lines = base;
    bclk(0, 1);
    hw_reset_n = 0;
    cyc(6);
    chk(data_lines_oe, 0);
    chk(hw_reset_active, 1);
    hw_reset_n = 1;
    address_lines = 19'(rnd());
    cyc(6);
    chk(data_lines_out, word(address_lines));
    burst_mode_enable = 0;
    pins(0, 1, 1);
    elevated_identification_level = 1;
    for (int a = 0; a < 2; a++) begin
      address_lines = {12'(rnd()), a[0], 6'h02};
      pins(0, 1, 0);
      pins(0, 1, 1);
      chk(sector_addr, address_lines);
    end
    cyc(8);
    elevated_identification_level = 0;
    chk({prot_n[15:0], unprot_n[15:0]}, 32'h0001_0001);
    end_sim();
  end
endmodule : burst_flash_bus_operation_decoder_bench

bind burst_flash_bus_operation_decoder bus_decoder_checker chk_i (
  .mclk                          (mclk),
  .reset                         (reset),
  .chip_select_n                 (chip_select_n),
  .output_enable_n               (output_enable_n),
  .write_enable_n                (write_enable_n),
  .hw_reset_n                    (hw_reset_n),
  .elevated_identification_level (elevated_identification_level),
  .data_lines_oe                 (data_lines_oe),
  .burst_last_word_n             (burst_last_word_n),
  .cmd_valid                     (cmd_valid),
  .cmd_ready                     (cmd_ready),
  .cmd_addr                      (cmd_addr),
  .cmd_data                      (cmd_data),
  .sector_protect                (sector_protect),
  .sector_unprotect              (sector_unprotect),
  .hw_reset_active               (hw_reset_active)
);
